//--- core/phy_link_debug_status.sv
// phy link debug status register with change events and interrupt
// assumes synchronous flag inputs and a single-cycle register port

`timescale 1ns/1ps

// How it works
// - debug flags register sits at offset 0xA0, software reads it
// - bit 4 shows receive high error rate state, zero after reset
// - bit 3 set while transmit lane has settled, zero after reset
// - bit 2 set once receive block alignment completed, zero after reset
// - bit 1 shows receive path ready, only while the 64b/66b path is used
// - bit 0 shows init done, only with the 64b/66b path in use
// - bit 0 set also means the transmit data path is ready
module phy_link_debug_status (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire phy_dbg_pkg::reg_req_t REG_REQ,
    input wire phy_dbg_pkg::phy_flags_t PHY_FLAGS,
    input wire logic TX_PATH_READY,
    input wire logic PATH_64B66B,
    output logic [phy_dbg_pkg::DATA_W-1:0] REG_RDATA,
    output logic IRQ
);
    import phy_dbg_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    regs_state_t s_q;
    regs_state_t s_d;
    phy_flags_t gated;
    logic [FLAG_W-1:0] gated_vec;
    logic [FLAG_W-1:0] level_vec;
    logic [FLAG_W-1:0] evt_vec;
    logic [FLAG_W-1:0] status_vec;
    logic [FLAG_W-1:0] clr_vec;
    logic [DATA_W-1:0] debug_word;
    logic hit_debug;
    logic hit_status;
    logic hit_mask;
    logic hit_edge;
    logic [FLAG_W-1:0] wdata_flags;
    logic irq_cause;

    // ------------------------------------------------------------
    // flag qualification
    // ------------------------------------------------------------
    always_comb
    begin
        gated = PHY_FLAGS;
        // outside the 64b/66b path these two flags carry no meaning
        gated.rx_path_ready_flag = PHY_FLAGS.rx_path_ready_flag & PATH_64B66B;
        // one flag for init done and transmit readiness together
        gated.phy_init_done = PHY_FLAGS.phy_init_done & TX_PATH_READY
            & PATH_64B66B;
    end

    assign gated_vec = gated;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_debug = (REG_REQ.addr == OFS_DEBUG_FLAGS);
    assign hit_status = (REG_REQ.addr == OFS_EVT_STATUS);
    assign hit_mask = (REG_REQ.addr == OFS_EVT_MASK);
    assign hit_edge = (REG_REQ.addr == OFS_EVT_EDGE);

    assign wdata_flags = REG_REQ.wdata[FLAG_W-1:0];

    // write one to clear the event bits
    assign clr_vec = (REG_REQ.wr && hit_status) ? wdata_flags : RST_STATUS;

    // ------------------------------------------------------------
    // per-flag tracking and sticky events
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi = gi + 1)
        begin : g_flag
            flag_edge #(
                .RST_LEVEL(RST_FLAGS[gi])
            ) u_edge (
                .clk(CORE_CLK),
                .nrst(NRST),
                .level_in(gated_vec[gi]),
                .both_edges(s_q.edge_q[gi]),
                .level_q(level_vec[gi]),
                .evt_q(evt_vec[gi])
            );
            event_sticky u_sticky (
                .clk(CORE_CLK),
                .nrst(NRST),
                .set(evt_vec[gi]),
                .clr(clr_vec[gi]),
                .q(status_vec[gi])
            );
        end
    endgenerate

    // reserved bits above the flags always read zero
    assign debug_word = {{(DATA_W-FLAG_W){1'b0}}, level_vec};

    // ------------------------------------------------------------
    // register file and read path
    // ------------------------------------------------------------
    // any unmasked pending event holds the interrupt up
    assign irq_cause = |(status_vec & s_q.mask_q);

    always_comb
    begin
        s_d = s_q;
        // a write to the debug flags offset is simply dropped
        if (REG_REQ.wr && hit_mask)
            s_d.mask_q = REG_REQ.wdata[FLAG_W-1:0];
        if (REG_REQ.wr && hit_edge)
            s_d.edge_q = REG_REQ.wdata[FLAG_W-1:0];
        s_d.rdata_q = RST_RDATA;
        if (REG_REQ.rd)
        begin
            if (hit_debug)
                s_d.rdata_q = debug_word;
            else if (hit_status)
                s_d.rdata_q = {{(DATA_W-FLAG_W){1'b0}}, status_vec};
            else if (hit_mask)
                s_d.rdata_q = {{(DATA_W-FLAG_W){1'b0}}, s_q.mask_q};
            else if (hit_edge)
                s_d.rdata_q = {{(DATA_W-FLAG_W){1'b0}}, s_q.edge_q};
        end
        // one cycle behind the status bits, keeps the output a flop
        s_d.irq_q = irq_cause;
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            s_q <= '{mask_q: RST_MASK, edge_q: RST_EDGE, rdata_q: RST_RDATA, irq_q: 1'b0};
        else
            s_q <= s_d;
    end

    assign REG_RDATA = s_q.rdata_q;
    assign IRQ = s_q.irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    sequence seq_read_debug;
        REG_REQ.rd && (REG_REQ.addr == OFS_DEBUG_FLAGS);
    endsequence

    sequence seq_write_debug;
        REG_REQ.wr && (REG_REQ.addr == OFS_DEBUG_FLAGS);
    endsequence

    sequence seq_flag_rises(int unsigned pos);
        !gated_vec[pos] ##1 gated_vec[pos];
    endsequence

    sequence seq_status_clear;
        REG_REQ.wr && (REG_REQ.addr == OFS_EVT_STATUS) && REG_REQ.wdata[POS_LANE]
            && !evt_vec[POS_LANE];
    endsequence

    sequence seq_read_status;
        REG_REQ.rd && (REG_REQ.addr == OFS_EVT_STATUS);
    endsequence

    sequence seq_lane_falls;
        level_vec[POS_LANE] && !PHY_FLAGS.tx_lane_settled;
    endsequence

    // ------------------------------------------------------------
    // checks on the register port
    // ------------------------------------------------------------
    // read of the debug offset shows the flags one cycle later
    AST_DEBUG_READ: assert property (
        seq_read_debug |=> (REG_RDATA[FLAG_W-1:0] == $past(level_vec)))
        else $error("debug flags read returned wrong value");

    // read data stand one cycle only
    AST_READ_ONE_CYCLE: assert property (
        !REG_REQ.rd |=> (REG_RDATA == RST_RDATA))
        else $error("read data present without a read");

    // status, mask and edge select read back one cycle later
    AST_STATUS_READ: assert property (
        seq_read_status |=> (REG_RDATA[FLAG_W-1:0] == $past(status_vec)))
        else $error("event status read returned wrong value");

    AST_MASK_WRITE: assert property (
        (REG_REQ.wr && (REG_REQ.addr == OFS_EVT_MASK)) |=> (s_q.mask_q == $past(wdata_flags)))
        else $error("mask write did not land");

    AST_MASK_READ: assert property (
        (REG_REQ.rd && (REG_REQ.addr == OFS_EVT_MASK))
            |=> (REG_RDATA[FLAG_W-1:0] == $past(s_q.mask_q)))
        else $error("mask read returned wrong value");

    AST_EDGE_WRITE: assert property (
        (REG_REQ.wr && (REG_REQ.addr == OFS_EVT_EDGE)) |=> (s_q.edge_q == $past(wdata_flags)))
        else $error("edge select write did not land");

    AST_EDGE_READ: assert property (
        (REG_REQ.rd && (REG_REQ.addr == OFS_EVT_EDGE))
            |=> (REG_RDATA[FLAG_W-1:0] == $past(s_q.edge_q)))
        else $error("edge select read returned wrong value");

    // offsets outside the map read as zero
    AST_UNMAPPED_READ: assert property (
        (REG_REQ.rd && (REG_REQ.addr != OFS_DEBUG_FLAGS) && (REG_REQ.addr != OFS_EVT_STATUS)
            && (REG_REQ.addr != OFS_EVT_MASK) && (REG_REQ.addr != OFS_EVT_EDGE))
            |=> (REG_RDATA == RST_RDATA))
        else $error("unmapped read returned data");

    // ------------------------------------------------------------
    // checks on the flag bits
    // ------------------------------------------------------------
    // high error rate bit follows its input with one cycle lag
    AST_HIGH_ERR_TRACK: assert property (
        ##1 (level_vec[POS_HIGH_ERR] == $past(PHY_FLAGS.rx_high_error_rate)))
        else $error("high error rate bit does not track input");

    // high error rate bit read back in place
    AST_HIGH_ERR_READ: assert property (
        PHY_FLAGS.rx_high_error_rate ##1 seq_read_debug |=> REG_RDATA[POS_HIGH_ERR])
        else $error("high error rate bit missing from read");

    // lane settled bit follows its input
    AST_LANE_TRACK: assert property (
        seq_flag_rises(POS_LANE) |=> level_vec[POS_LANE]
            && !$past(level_vec[POS_LANE]))
        else $error("lane settled bit wrong");

    AST_LANE_CLEAR: assert property (
        !PHY_FLAGS.tx_lane_settled |=> !level_vec[POS_LANE])
        else $error("lane settled bit set while lane not settled");

    // block aligned bit shows completed alignment
    AST_BLOCK_TRACK: assert property (
        PHY_FLAGS.rx_block_aligned [*2] |-> level_vec[POS_BLOCK])
        else $error("block aligned bit not set after alignment");

    AST_BLOCK_CLEAR: assert property (
        !PHY_FLAGS.rx_block_aligned |=> !level_vec[POS_BLOCK])
        else $error("block aligned bit set before alignment");

    // receive path ready masked off outside the 64b/66b path
    AST_RX_READY_PATH: assert property (
        !PATH_64B66B |=> !level_vec[POS_RX_READY])
        else $error("receive ready shown outside the 64b/66b path");

    AST_RX_READY_SET: assert property (
        (PATH_64B66B && PHY_FLAGS.rx_path_ready_flag) |=> level_vec[POS_RX_READY])
        else $error("receive ready not shown");

    AST_RX_READY_CLEAR: assert property (
        !PHY_FLAGS.rx_path_ready_flag |=> !level_vec[POS_RX_READY])
        else $error("receive ready shown while path not ready");

    // init done needs the 64b/66b path and the initialisation itself
    AST_INIT_DONE_COND: assert property (
        level_vec[POS_INIT_DONE] |-> $past(PATH_64B66B) && $past(PHY_FLAGS.phy_init_done))
        else $error("init done shown without its cause");

    AST_INIT_DONE_SET: assert property (
        (PHY_FLAGS.phy_init_done && TX_PATH_READY && PATH_64B66B)
            |=> level_vec[POS_INIT_DONE])
        else $error("init done not shown");

    AST_INIT_PATH: assert property (
        !PATH_64B66B |=> !level_vec[POS_INIT_DONE])
        else $error("init done shown outside the 64b/66b path");

    // init done never shown while the transmit path is not ready
    AST_INIT_TX_READY: assert property (
        !TX_PATH_READY |=> !level_vec[POS_INIT_DONE] ##1 !REG_RDATA[POS_INIT_DONE])
        else $error("init done shown with transmit path not ready");

    // reserved bits read zero on every read
    AST_RESERVED_ZERO: assert property (
        REG_REQ.rd |=> (REG_RDATA[DATA_W-1:FLAG_W] == '0))
        else $error("reserved read bits not zero");

    // writing the debug offset changes neither flags nor controls
    AST_WRITE_IGNORED: assert property (
        seq_write_debug |=> $stable(s_q.mask_q) && $stable(s_q.edge_q))
        else $error("write to read-only debug register had an effect");

    // ------------------------------------------------------------
    // checks on events and interrupt
    // ------------------------------------------------------------
    // a settled-lane event raises its status bit, a clear removes it
    AST_EVENT_STICKY: assert property (
        evt_vec[POS_LANE] |=> status_vec[POS_LANE] [*2] or seq_status_clear)
        else $error("event status bit not sticky");

    AST_EVENT_CLEAR: assert property (
        seq_status_clear |=> !status_vec[POS_LANE])
        else $error("status bit not cleared by write of one");

    // a rising flag gives an event pulse in the same cycle as its level is captured
    AST_EVENT_RISE: assert property (
        seq_flag_rises(POS_BLOCK) |=> evt_vec[POS_BLOCK])
        else $error("rising flag gave no event");

    // no change, no event
    AST_NO_EVENT_STEADY: assert property (
        (gated_vec == level_vec) |=> (evt_vec == '0))
        else $error("event without a flag change");

    // falls count only where the edge select asks for both edges
    AST_FALL_EVENT: assert property (
        seq_lane_falls ##0 s_q.edge_q[POS_LANE] |=> evt_vec[POS_LANE])
        else $error("falling lane flag gave no event");

    AST_FALL_IGNORED: assert property (
        seq_lane_falls ##0 !s_q.edge_q[POS_LANE] |=> !evt_vec[POS_LANE])
        else $error("falling lane flag gave an event on rising-only select");

    // a lane event always lands, even beside a clear
    AST_SET_WINS: assert property (
        evt_vec[POS_LANE] |=> status_vec[POS_LANE])
        else $error("lane event did not reach its status bit");

    // writing all ones clears every pending bit that gets no new event in the same cycle
    AST_CLEAR_ALL: assert property (
        (REG_REQ.wr && (REG_REQ.addr == OFS_EVT_STATUS) && (&wdata_flags) && (evt_vec == '0))
            |=> (status_vec == '0))
        else $error("status bits left after clear of all");

    // interrupt follows unmasked status one cycle later
    AST_IRQ_LEVEL: assert property (
        ##1 (IRQ == $past(irq_cause)))
        else $error("interrupt level wrong");

    AST_IRQ_LANE: assert property (
        (status_vec[POS_LANE] && s_q.mask_q[POS_LANE]) |=> IRQ)
        else $error("unmasked lane event gave no interrupt");

    // a fully closed mask keeps the interrupt low
    AST_IRQ_MASKED: assert property (
        (s_q.mask_q == '0) |=> !IRQ)
        else $error("interrupt with every event masked");

endmodule

//--- core/phy_dbg_pkg.sv
// constants and carrier types of the phy link debug status block
// assumes one core clock and a plain single-cycle register port

package phy_dbg_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned FLAG_W = 5;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DEBUG_FLAGS = 8'hA0;
    localparam logic [7:0] OFS_EVT_STATUS = 8'hA4;
    localparam logic [7:0] OFS_EVT_MASK = 8'hA8;
    localparam logic [7:0] OFS_EVT_EDGE = 8'hAC;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned POS_HIGH_ERR = 4;
    localparam int unsigned POS_LANE = 3;
    localparam int unsigned POS_BLOCK = 2;
    localparam int unsigned POS_RX_READY = 1;
    localparam int unsigned POS_INIT_DONE = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [4:0] RST_MASK = 5'h00;
    localparam logic [4:0] RST_EDGE = 5'h00;
    localparam logic [4:0] RST_STATUS = 5'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic rx_high_error_rate;
        logic tx_lane_settled;
        logic rx_block_aligned;
        logic rx_path_ready_flag;
        logic phy_init_done;
    } phy_flags_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic level_q;
        logic evt_q;
    } edge_state_t;

    typedef struct packed {
        logic bit_q;
    } sticky_state_t;

    typedef struct packed {
        logic [FLAG_W-1:0] mask_q;
        logic [FLAG_W-1:0] edge_q;
        logic [DATA_W-1:0] rdata_q;
        logic irq_q;
    } regs_state_t;

endpackage

//--- core/flag_edge.sv
// one status flag: registered level plus a change-event pulse
// assumes the level is synchronous to clk

`timescale 1ns/1ps

module flag_edge #(
    parameter logic RST_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic level_in,
    input wire logic both_edges,
    output logic level_q,
    output logic evt_q
);
    import phy_dbg_pkg::*;

    edge_state_t s_q;
    edge_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.level_q = level_in;
        // rising edges always count, falling ones only when asked
        s_d.evt_q = (level_in & ~s_q.level_q) | (both_edges & ~level_in & s_q.level_q);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_q <= '{level_q: RST_LEVEL, evt_q: 1'b0};
        else
            s_q <= s_d;
    end

    assign level_q = s_q.level_q;
    assign evt_q = s_q.evt_q;

endmodule

//--- core/event_sticky.sv
// one sticky event bit, cleared by software
// assumes set and clr are one-cycle pulses synchronous to clk

`timescale 1ns/1ps

module event_sticky (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    import phy_dbg_pkg::*;

    sticky_state_t s_q;
    sticky_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        // set beats clear so a coincident event is never lost
        if (set)
            s_d.bit_q = 1'b1;
        else if (clr)
            s_d.bit_q = 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_q <= '{bit_q: 1'b0};
        else
            s_q <= s_d;
    end

    assign q = s_q.bit_q;

endmodule

//--- testbench/testbench.sv
// self-checking bench for the phy link debug status block
// assumes the core/ package and design files are compiled first

`timescale 1ns/1ps

module testbench;
    import phy_dbg_pkg::*;

    // ------------------------------------------------------------
    // clock, stimulus and design
    // ------------------------------------------------------------
    logic core_clk;
    logic nrst;
    reg_req_t reg_req;
    phy_flags_t phy_flags;
    logic tx_path_ready;
    logic path_64b66b;
    logic [DATA_W-1:0] reg_rdata;
    logic irq;
    int err_count;
    int compares;

    phy_link_debug_status phy_link_debug_status_inst (
        .CORE_CLK(core_clk),
        .NRST(nrst),
        .REG_REQ(reg_req),
        .PHY_FLAGS(phy_flags),
        .TX_PATH_READY(tx_path_ready),
        .PATH_64B66B(path_64b66b),
        .REG_RDATA(reg_rdata),
        .IRQ(irq)
    );

    initial
    begin
        core_clk = 1'h0;
        forever
        begin
            #2.5 core_clk = ~core_clk;
        end
    end

    // ------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (err_count == 0 && compares > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // register port and flag drivers
    // ------------------------------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge core_clk);
        reg_req <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'h0, rd: 1'h1};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        check_word(reg_rdata, exp);
    endtask

    // four edges cover capture, event, status and interrupt stages
    task automatic apply(input logic [4:0] f, input logic tx, input logic path);
        @(posedge core_clk);
        phy_flags <= f;
        tx_path_ready <= tx;
        path_64b66b <= path;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        // step off the edge that may be launching a change
        #1;
        while (irq !== exp && n < 8)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check_bit(irq, exp);
        if (irq !== exp)
        begin
            wrap_up();
        end
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'h0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_values();
        #1;
        check_bit(irq, 1'h0);
        read_check(8'hA0, 32'h0000_0000);
        read_check(8'hA4, 32'h0000_0000);
        read_check(8'hA8, 32'h0000_0000);
        read_check(8'hAC, 32'h0000_0000);
    endtask

    task automatic flag_bits();
        for (int i = 0; i < 5; i++)
        begin
            apply(5'h01 << i, 1'h1, 1'h1);
            read_check(8'hA0, 32'h0000_0001 << i);
        end
        apply(5'h1F, 1'h1, 1'h1);
        read_check(8'hA0, 32'h0000_001F);
    endtask

    // bit 0 needs transmit readiness, bits 1 and 0 need the 64b/66b path
    task automatic qualified_bits();
        apply(5'h1F, 1'h0, 1'h1);
        read_check(8'hA0, 32'h0000_001E);
        apply(5'h1F, 1'h1, 1'h0);
        read_check(8'hA0, 32'h0000_001C);
        apply(5'h03, 1'h0, 1'h0);
        read_check(8'hA0, 32'h0000_0000);
    endtask

    task automatic write_ignored();
        apply(5'h15, 1'h1, 1'h1);
        reg_write(8'hA0, 32'hFFFF_FFFF);
        read_check(8'hA0, 32'h0000_0015);
        reg_write(8'hA0, 32'h0000_0000);
        read_check(8'hA0, 32'h0000_0015);
        read_check(8'hA1, 32'h0000_0000);
        read_check(8'h00, 32'h0000_0000);
        read_check(8'hFF, 32'h0000_0000);
    endtask

    task automatic irq_flow();
        apply(5'h00, 1'h1, 1'h1);
        reg_write(8'hA4, 32'h0000_001F);
        read_check(8'hA4, 32'h0000_0000);
        reg_write(8'hA8, 32'h0000_0008);
        read_check(8'hA8, 32'h0000_0008);
        wait_irq(1'h0);
        apply(5'h08, 1'h1, 1'h1);
        read_check(8'hA4, 32'h0000_0008);
        wait_irq(1'h1);
        reg_write(8'hA8, 32'h0000_0000);
        wait_irq(1'h0);
        reg_write(8'hA8, 32'h0000_0008);
        wait_irq(1'h1);
        reg_write(8'hA4, 32'h0000_0008);
        wait_irq(1'h0);
        read_check(8'hA4, 32'h0000_0000);
        // rising-only select ignores the drop
        apply(5'h00, 1'h1, 1'h1);
        read_check(8'hA4, 32'h0000_0000);
        wait_irq(1'h0);
        reg_write(8'hAC, 32'h0000_0008);
        read_check(8'hAC, 32'h0000_0008);
        apply(5'h08, 1'h1, 1'h1);
        reg_write(8'hA4, 32'h0000_0008);
        wait_irq(1'h0);
        apply(5'h00, 1'h1, 1'h1);
        read_check(8'hA4, 32'h0000_0008);
        wait_irq(1'h1);
    endtask

    task automatic mid_reset();
        do_reset();
        #1;
        check_bit(irq, 1'h0);
        read_check(8'hA8, 32'h0000_0000);
        read_check(8'hAC, 32'h0000_0000);
        read_check(8'hA4, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        err_count = 0;
        compares = 0;
        nrst = 1'h0;
        reg_req = '0;
        phy_flags = '0;
        tx_path_ready = 1'h0;
        path_64b66b = 1'h0;
        do_reset();
        reset_values();
        flag_bits();
        qualified_bits();
        write_ignored();
        irq_flow();
        mid_reset();
        wrap_up();
    end

endmodule
